// File: core/sac_pkg.sv
// constants and types shared by the serial converter control block
`default_nettype none

package sac_pkg;

  // word widths
  localparam int RES_W   = 10;                   // conversion result width
  localparam int ADDR_W  = 4;                    // channel address width
  localparam int CNT_W   = 5;                    // shift-clock edge counter width
  localparam int WIN_W   = 8;                    // slow-mode window counter width

  // shift-clock edge numbers within one transfer
  localparam logic [CNT_W-1:0] ADDR_EDGES  = 5'h04;  // rising edges that carry the address
  localparam logic [CNT_W-1:0] SAMPLE_EDGE = 5'h04;  // falling edge that opens sampling
  localparam logic [CNT_W-1:0] CONV_EDGE   = 5'h0A;  // falling edge that holds and converts
  localparam logic [CNT_W-1:0] FULL_XFER   = 5'h10;  // longest transfer, also the mode 6 reload edge
  localparam logic [CNT_W-1:0] CNT_ZERO    = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE     = 5'h01;

  // system clock and the slow-mode window
  localparam int CLK_PERIOD_NS = 40;             // 25 MHz system clock
  localparam int SLOW_WIN_NS   = 9500;           // latest 11th rising edge after the 10th fall
  localparam int SLOW_WIN_CYC_I = SLOW_WIN_NS / CLK_PERIOD_NS;  // rounds down
  localparam logic [WIN_W-1:0] SLOW_WIN_CYC = SLOW_WIN_CYC_I[WIN_W-1:0];

  // default conversion time in system clocks
  localparam int CONV_CLKS_DEF = 22;

  // frame state of the serial port
  typedef enum logic [1:0] {
    ST_OFF,                                      // select high, port disabled
    ST_XFER,                                     // select low, edges counted
    ST_LOST                                      // synchronisation lost, wait for select high
  } sac_frame_t;

endpackage : sac_pkg

`default_nettype wire

// File: core/sac_sync.sv
// three-stage synchroniser; a change is taken once stages two and three agree
`default_nettype none

module sac_sync
  import sac_pkg::*;
#(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,       // system clock
  input  wire logic         rst_b,     // synchronous reset, active low
  input  wire logic [W-1:0] d,         // asynchronous input
  output logic      [W-1:0] q          // filtered, synchronised level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sac_sync_st_t;

  sac_sync_st_t r_r;
  sac_sync_st_t r_nxt;

  // shift chain; the output follows only where the last two stages agree
  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    for (int i = 0; i < W; i++) begin
      if (r_r.s2[i] == r_r.s3[i]) begin
        r_nxt.q[i] = r_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.q;

endmodule : sac_sync

`default_nettype wire

// File: core/sac_fifo.sv
// result FIFO with valid and ready on both sides
`default_nettype none

module sac_fifo
  import sac_pkg::*;
#(
  parameter int WIDTH = RES_W,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,        // system clock
  input  wire logic             rst_b,      // synchronous reset, active low
  input  wire logic             in_valid,   // write request
  output logic                  in_ready,   // space available
  input  wire logic [WIDTH-1:0] in_data,    // write data
  output logic                  out_valid,  // data available
  input  wire logic             out_ready,  // read acknowledge
  output logic      [WIDTH-1:0] out_data    // head word
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0]   CNT_FULL = DEPTH[PTR_W:0];
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wptr;
    logic [PTR_W-1:0]            rptr;
    logic [PTR_W:0]              cnt;
  } sac_fifo_st_t;

  sac_fifo_st_t r_r;
  sac_fifo_st_t r_nxt;
  logic         wr;
  logic         rd;

  // honest flags from the word count
  assign in_ready  = (r_r.cnt != CNT_FULL);
  assign out_valid = (r_r.cnt != '0);
  assign out_data  = r_r.mem[r_r.rptr];
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    r_nxt = r_r;
    if (wr) begin
      r_nxt.mem[r_r.wptr] = in_data;
      r_nxt.wptr = (r_r.wptr == PTR_LAST) ? '0 : r_r.wptr + 1'b1;
    end
    if (rd) begin
      r_nxt.rptr = (r_r.rptr == PTR_LAST) ? '0 : r_r.rptr + 1'b1;
    end
    if (wr && !rd) begin
      r_nxt.cnt = r_r.cnt + 1'b1;
    end else if (rd && !wr) begin
      r_nxt.cnt = r_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

endmodule : sac_fifo

`default_nettype wire

// File: core/sac_ctrl.sv
// serial control and readout logic of the successive-approximation converter
//
// Summary of operation
// - address latched on first four rising edges
// - sampling from fourth to tenth falling edge
// - nine further result bits, one per fall
// - tenth falling edge starts the conversion
// - select high: inputs ignored, output released
// - select low: inputs enabled, output driven
// - end flag low at tenth fall, high when done
// - output forced low at tenth fall
// - previous MSB on select, end flag, or sixteenth
// - fast mode: transfer ends before conversion
// - select rise releases output, disables inputs
// - mode follows clock rate, clock count and select
// - address MSB first, then ignored
// - slow mode: eleventh rise before completion, in window
// - held select, fast: end flag rise presents new MSB
`default_nettype none

module sac_ctrl
  import sac_pkg::*;
#(
  parameter int CONV_CLKS  = CONV_CLKS_DEF,   // conversion time in system clocks
  parameter int FIFO_DEPTH = 8                // results held for readout
) (
  input  wire logic              clk,          // 25 MHz system clock
  input  wire logic              rst_b,        // synchronous reset, active low
  input  wire logic              io_clk,       // host shift clock, link domain
  input  wire logic              cs_b,         // device select pin, active low
  input  wire logic              addr_i,       // serial channel address pin
  output logic                   dout_o,       // serial result output value
  output logic                   dout_oe_b,    // result output enable, low drives
  output logic                   eoc_o,        // end of conversion, high when done
  output logic      [ADDR_W-1:0] mux_addr_o,   // channel to the analog multiplexer
  output logic                   mux_valid_o,  // channel address complete
  output logic                   sample_o,     // sampling phase active
  output logic                   conv_start_o, // one-cycle start of conversion
  input  wire logic [RES_W-1:0]  adc_code_i    // code from the converter core
);

  localparam int CC_W = $clog2(CONV_CLKS + 1);
  localparam logic [CC_W-1:0] CONV_LOAD = CC_W'(CONV_CLKS - 1);

  // ---------------------------------------------------------------
  // link domain: shift-clock edges become toggles, address bit held
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rtog;                                // flips on every rising edge
    logic abit;                                // address pin at that edge
  } sac_lrise_t;

  typedef struct packed {
    logic ftog;                                // flips on every falling edge
  } sac_lfall_t;

  sac_lrise_t lr_r;
  sac_lrise_t lr_nxt;
  sac_lfall_t lf_r;
  sac_lfall_t lf_nxt;

  // rising-edge capture; the address bit crosses beside its toggle so both arrive together
  always_comb begin
    lr_nxt      = lr_r;
    lr_nxt.rtog = !lr_r.rtog;
    lr_nxt.abit = addr_i;
  end

  always_ff @(posedge io_clk) begin
    if (!rst_b) begin
      lr_r <= '0;
    end else begin
      lr_r <= lr_nxt;
    end
  end

  // falling-edge toggle
  always_comb begin
    lf_nxt      = lf_r;
    lf_nxt.ftog = !lf_r.ftog;
  end

  always_ff @(negedge io_clk) begin
    if (!rst_b) begin
      lf_r <= '0;
    end else begin
      lf_r <= lf_nxt;
    end
  end

  // ---------------------------------------------------------------
  // crossings into the system clock domain
  // ---------------------------------------------------------------
  logic cs_q;
  logic rt_q;
  logic ft_q;
  logic ab_q;

  sac_sync #(.W(1), .RST_VAL(1'b1)) u_sync_cs (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (cs_b),
    .q     (cs_q)
  );

  sac_sync #(.W(3), .RST_VAL(3'h0)) u_sync_tog (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({lr_r.rtog, lf_r.ftog, lr_r.abit}),
    .q     ({rt_q, ft_q, ab_q})
  );

  // ---------------------------------------------------------------
  // result FIFO between the converter and the readout register
  // ---------------------------------------------------------------
  logic             push;
  logic             pop;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [RES_W-1:0] fifo_out_data;

  sac_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (adc_code_i),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------
  // system domain state
  // ---------------------------------------------------------------
  typedef struct packed {
    sac_frame_t       st;
    logic             cs_last;                 // previous synchronised select
    logic             rt_last;                 // previous rising toggle
    logic             ft_last;                 // previous falling toggle
    logic [CNT_W-1:0] rise_cnt;                // rising edges in this transfer
    logic [CNT_W-1:0] fall_cnt;                // falling edges in this transfer
    logic [ADDR_W-1:0] addr;                   // channel address
    logic             addr_ok;                 // all address bits in
    logic             sampling;                // sampling window
    logic             busy;                    // conversion running
    logic [CC_W-1:0]  conv_cnt;                // conversion clocks left
    logic [WIN_W-1:0] win_cnt;                 // clocks since the tenth fall
    logic             eoc;                     // end-of-conversion level
    logic             eoc_rose;                // result pushed last cycle
    logic             start;                   // conversion start pulse
    logic [RES_W-1:0] shreg;                   // output shift register
    logic [RES_W-1:0] last_res;                // most recent result read out
    logic             oe_b;                    // output enable, low drives
  } sac_ctrl_st_t;

  sac_ctrl_st_t r_r;
  sac_ctrl_st_t r_nxt;

  logic             cs_fall;
  logic             cs_rise;
  logic             rise_ev;
  logic             fall_ev;
  logic             load;
  logic [CNT_W-1:0] fall_new;

  // edge events seen in the system domain
  assign cs_fall  = r_r.cs_last && !cs_q;
  assign cs_rise  = !r_r.cs_last && cs_q;
  assign rise_ev  = (rt_q != r_r.rt_last);
  assign fall_ev  = (ft_q != r_r.ft_last);
  assign fall_new = (r_r.fall_cnt == FULL_XFER) ? r_r.fall_cnt : r_r.fall_cnt + CNT_ONE;

  // next-state logic of the whole serial port
  always_comb begin
    r_nxt          = r_r;
    push           = 1'b0;
    load           = 1'b0;
    r_nxt.start    = 1'b0;
    r_nxt.eoc_rose = 1'b0;
    r_nxt.cs_last  = cs_q;
    r_nxt.rt_last  = rt_q;
    r_nxt.ft_last  = ft_q;

    // conversion timer; a full FIFO stalls completion
    if (r_r.busy) begin
      if (r_r.conv_cnt != '0) begin
        r_nxt.conv_cnt = r_r.conv_cnt - 1'b1;
      end else if (fifo_in_ready) begin
        push           = 1'b1;
        r_nxt.busy     = 1'b0;
        r_nxt.eoc      = 1'b1;
        r_nxt.eoc_rose = 1'b1;
      end
      if (r_r.win_cnt != SLOW_WIN_CYC) begin
        r_nxt.win_cnt = r_r.win_cnt + 1'b1;
      end
    end

    case (r_r.st)
      ST_OFF: begin
        r_nxt.oe_b = 1'b1;
        if (cs_fall) begin
          r_nxt.st = ST_XFER;
          load     = 1'b1;
        end
      end
      ST_XFER: begin
        if (cs_rise) begin
          r_nxt.st       = ST_OFF;
          r_nxt.oe_b     = 1'b1;
          r_nxt.sampling = 1'b0;
        end else begin
          // address shift and slow-mode synchronisation check
          if (rise_ev) begin
            if (r_r.rise_cnt < ADDR_EDGES) begin
              r_nxt.addr = {r_r.addr[ADDR_W-2:0], ab_q};
            end
            if (r_r.rise_cnt == ADDR_EDGES - CNT_ONE) begin
              r_nxt.addr_ok = 1'b1;
            end
            if (r_r.rise_cnt == CONV_EDGE && r_r.fall_cnt == CONV_EDGE &&
                (!r_r.busy || r_r.win_cnt == SLOW_WIN_CYC)) begin
              r_nxt.st = ST_LOST;
            end
            if (r_r.rise_cnt != FULL_XFER) begin
              r_nxt.rise_cnt = r_r.rise_cnt + CNT_ONE;
            end
          end
          // data shift, sampling window and conversion start
          if (fall_ev) begin
            r_nxt.fall_cnt = fall_new;
            r_nxt.shreg    = {r_r.shreg[RES_W-2:0], 1'b0};
            if (fall_new == SAMPLE_EDGE) begin
              r_nxt.sampling = 1'b1;
            end
            if (fall_new == CONV_EDGE) begin
              r_nxt.sampling = 1'b0;
              r_nxt.shreg    = '0;
              r_nxt.busy     = 1'b1;
              r_nxt.conv_cnt = CONV_LOAD;
              r_nxt.win_cnt  = '0;
              r_nxt.eoc      = 1'b0;
              r_nxt.start    = 1'b1;
            end
            if (fall_new == FULL_XFER && r_r.fall_cnt != FULL_XFER &&
                !r_r.busy && r_r.fall_cnt != CONV_EDGE - CNT_ONE) begin
              load = 1'b1;
            end
          end
          // held select: a completed conversion after a finished transfer reloads
          if (r_r.eoc_rose && r_r.rise_cnt == r_r.fall_cnt && !rise_ev && !fall_ev &&
              (r_r.fall_cnt == CONV_EDGE || r_r.fall_cnt == FULL_XFER)) begin
            load = 1'b1;
          end
        end
      end
      ST_LOST: begin
        // clocks ignored until the host toggles select
        if (cs_rise) begin
          r_nxt.st   = ST_OFF;
          r_nxt.oe_b = 1'b1;
        end
      end
      default: begin
        r_nxt.st = ST_OFF;
      end
    endcase

    // new frame: counters cleared, previous result presented MSB first
    if (load) begin
      r_nxt.rise_cnt = CNT_ZERO;
      r_nxt.fall_cnt = CNT_ZERO;
      r_nxt.addr_ok  = 1'b0;
      r_nxt.sampling = 1'b0;
      r_nxt.oe_b     = 1'b0;
      if (fifo_out_valid) begin
        r_nxt.shreg    = fifo_out_data;
        r_nxt.last_res = fifo_out_data;
      end else begin
        r_nxt.shreg    = r_r.last_res;
      end
    end
  end

  // drain one result per new frame
  assign pop = load && fifo_out_valid;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_r <= '{st: ST_OFF, cs_last: 1'b1, eoc: 1'b1, oe_b: 1'b1, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from the state register
  assign dout_o       = r_r.shreg[RES_W-1];
  assign dout_oe_b    = r_r.oe_b;
  assign eoc_o        = r_r.eoc;
  assign mux_addr_o   = r_r.addr;
  assign mux_valid_o  = r_r.addr_ok;
  assign sample_o     = r_r.sampling;
  assign conv_start_o = r_r.start;

endmodule : sac_ctrl

`default_nettype wire

// File: testbench/sac_chk.sv
// port assertions for the serial converter control block
`default_nettype none

module sac_chk
  import sac_pkg::*;
#(
  parameter int CONV_CLKS = 22
) (
  input wire logic              clk,          // system clock
  input wire logic              rst_b,        // reset, active low
  input wire logic              io_clk,       // shift clock
  input wire logic              cs_b,         // select, active low
  input wire logic              addr_i,       // address pin
  input wire logic              dout_o,       // result bit
  input wire logic              dout_oe_b,    // low drives
  input wire logic              eoc_o,        // end of conversion
  input wire logic [ADDR_W-1:0] mux_addr_o,   // channel
  input wire logic              mux_valid_o,  // channel complete
  input wire logic              sample_o,     // sampling phase
  input wire logic              conv_start_o, // start pulse
  input wire logic [RES_W-1:0]  adc_code_i    // converter code
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] cnt_r;   // cycles since the start pulse
  logic [7:0] cnt_nxt;

  // count cycles while eoc is low, restarting at each start pulse
  always_comb begin
    cnt_nxt = eoc_o ? 8'h00 : cnt_r + 8'h01;
    if (conv_start_o) cnt_nxt = 8'h01;
  end

  always_ff @(posedge clk) cnt_r <= rst_b ? cnt_nxt : 8'h00;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // no second start may follow closely
  sequence s_quiet;
    !conv_start_o [*3];
  endsequence

  a_start_marks: assert property (conv_start_o |-> !eoc_o && !sample_o && !dout_o)
    else $error("start without eoc low, sampling end and zero output");
  a_start_pulse: assert property (conv_start_o |-> $past(sample_o) ##1 s_quiet)
    else $error("start not after sampling or not a single pulse");
  a_eoc_cause: assert property ($fell(eoc_o) |-> conv_start_o)
    else $error("eoc fell without a start");
  a_conv_time: assert property ($rose(eoc_o) |-> cnt_r == 8'(CONV_CLKS))
    else $error("conversion time wrong");
  a_idle_release: assert property (cs_b [*6] |-> dout_oe_b)
    else $error("output driven while deselected");
  a_sel_drive: assert property (!cs_b [*6] |-> !dout_oe_b)
    else $error("output released while selected");
  a_oe_on: assert property ($fell(dout_oe_b) |-> $past(cs_b, 3) == 1'b0)
    else $error("output driven without select");
  a_oe_off: assert property ($rose(dout_oe_b) |-> $past(cs_b, 2))
    else $error("output released without select rise");
  a_sample_addr: assert property (sample_o |-> mux_valid_o)
    else $error("sampling before channel complete");
  a_addr_hold: assert property ($rose(mux_valid_o) |=> $stable(mux_addr_o) [*8])
    else $error("channel changed after capture");

endmodule : sac_chk

`default_nettype wire

// File: testbench/sac_host.sv
// host serial port model: select, shift clock and address, reads results
`default_nettype none

module sac_host (
  output logic     cs_b,      // select, active low
  output logic     io_clk,    // shift clock, also toggled outside frames by idle
  output logic     addr_i,    // address, msb first
  input wire logic dout_line  // resolved result wire
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle levels
  initial begin
    cs_b = 1'b1;
    io_clk = 1'b0;
    addr_i = 1'b0;
  end

  // shift clocks with select high, which must be ignored
  task idle(input int n);
    #13;
    repeat (n) begin
      addr_i = ~addr_i;
      #80 io_clk = 1'b1;
      #80 io_clk = 1'b0;
    end
  endtask : idle

  // one transfer of n clocks; the low phase after fall p is stretched
  task frame(input int n, input logic [3:0] a, input logic keep, input int p, output logic [9:0] d);
    int j;
    d = 10'h000;
    #13;
    cs_b = 1'b0;
    #320;
    for (j = 1; j <= ((n > 11) ? n : 11); j++) begin
      addr_i = (j <= 4) ? a[4-j] : ~addr_i;
      #80;
      if (j <= n) io_clk = 1'b1;
      if (j == 1 || (j >= 3 && j <= 11)) d = {d[8:0], dout_line};
      #80;
      if (j <= n) io_clk = 1'b0;
      if (j == p) #3000;
    end
    if (!keep) cs_b = 1'b1;
  endtask : frame

endmodule : sac_host

`default_nettype wire

// File: testbench/tb.sv
// testbench for the serial converter control block and its result FIFO
`default_nettype none

module tb
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int CONV_CLKS = 40;  // longer than the six clocks after the tenth fall of a 16-clock transfer

  logic             clk, rst_b;
  wire              cs_b, io_clk, addr_i, dout_w;
  logic             dout_o, dout_oe_b, eoc_o, mux_valid_o, sample_o, conv_start_o;
  logic [3:0]       mux_addr_o;
  logic [9:0]       adc_code;
  int               miscompares, checked, starts, cycles;

  // result wire floats while the output is released
  assign dout_w = dout_oe_b ? 1'bz : dout_o;

  sac_ctrl #(.CONV_CLKS(CONV_CLKS)) sac_ctrl_i (.clk(clk), .rst_b(rst_b), .io_clk(io_clk), .cs_b(cs_b),
    .addr_i(addr_i), .dout_o(dout_o), .dout_oe_b(dout_oe_b), .eoc_o(eoc_o), .mux_addr_o(mux_addr_o),
    .mux_valid_o(mux_valid_o), .sample_o(sample_o), .conv_start_o(conv_start_o), .adc_code_i(adc_code));
  sac_host sac_host_i (.cs_b(cs_b), .io_clk(io_clk), .addr_i(addr_i), .dout_line(dout_w));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // start pulses are counted; a hang is cut short
  always @(negedge clk) begin
    cycles++;
    if (conv_start_o === 1'b1) starts++;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task report_and_stop();
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // eoc must fall, then rise within a bounded wait
  task wait_eoc();
    int n;
    for (n = 0; n < 100 && eoc_o !== 1'b0; n++) @(negedge clk);
    chk(eoc_o, 1'b0);
    for (n = 0; n < 200 && eoc_o !== 1'b1; n++) @(negedge clk);
    chk(eoc_o, 1'b1);
  endtask : wait_eoc

  task t_idle();
    sac_host_i.idle(12);
    @(negedge clk);
    chk({mux_valid_o, eoc_o, dout_oe_b}, 3'b011);
  endtask : t_idle

  task t_short();
    logic [9:0] d;
    sac_host_i.frame(9, 4'h3, 1'b0, 0, d);
    chk(mux_addr_o, 4'h3);
    chk(d, 10'h000);
    repeat (60) @(negedge clk);
    chk(16'(starts), 16'h0000);
  endtask : t_short

  task t_mode1();
    logic [9:0] d;
    @(posedge clk) adc_code <= 10'h2C5;
    sac_host_i.frame(10, 4'hA, 1'b0, 0, d);
    chk(mux_addr_o, 4'hA);
    chk(d, 10'h000);
    wait_eoc();
    chk(16'(starts), 16'h0001);
  endtask : t_mode1

  task t_mode3();
    logic [9:0] d;
    @(posedge clk) adc_code <= 10'h155;
    sac_host_i.frame(12, 4'h5, 1'b0, 0, d);
    chk(d, 10'h2C5);
    wait_eoc();
  endtask : t_mode3

  // select held low through 10, 16, slow 16 and 10 clock transfers
  task t_held();
    logic [9:0] d;
    @(posedge clk) adc_code <= 10'h3A6;
    sac_host_i.frame(10, 4'h1, 1'b1, 0, d);
    chk(d, 10'h155);
    wait_eoc();
    @(posedge clk) adc_code <= 10'h0D9;
    sac_host_i.frame(16, 4'h2, 1'b1, 0, d);
    chk(d, 10'h3A6);
    wait_eoc();
    @(posedge clk) adc_code <= 10'h2AA;
    sac_host_i.frame(16, 4'h4, 1'b1, 11, d);
    chk(d, 10'h0D9);
    @(posedge clk) adc_code <= 10'h111;
    sac_host_i.frame(10, 4'h8, 1'b0, 0, d);
    chk(d, 10'h2AA);
    wait_eoc();
    chk(16'(starts), 16'h0006);
  endtask : t_held

  // the queued result comes out once, then the empty queue repeats the last one read
  task t_fifo();
    logic [9:0] d;
    sac_host_i.frame(9, 4'hC, 1'b0, 0, d);
    chk(d, 10'h111);
    chk(mux_addr_o, 4'hC);
    repeat (8) @(negedge clk);
    sac_host_i.frame(9, 4'h6, 1'b0, 0, d);
    chk(d, 10'h111);
    repeat (60) @(negedge clk);
    chk(16'(starts), 16'h0006);
  endtask : t_fifo

  // reset needs shift clocks while held, then the scenarios run
  initial begin
    rst_b = 1'b0;
    adc_code = 10'h000;
    sac_host_i.idle(3);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_idle();
    t_short();
    t_mode1();
    t_mode3();
    t_held();
    t_fifo();
    report_and_stop();
  end

endmodule : tb

bind sac_ctrl sac_chk #(.CONV_CLKS(CONV_CLKS)) sac_chk_i (.clk(clk), .rst_b(rst_b), .io_clk(io_clk),
  .cs_b(cs_b), .addr_i(addr_i), .dout_o(dout_o), .dout_oe_b(dout_oe_b), .eoc_o(eoc_o),
  .mux_addr_o(mux_addr_o), .mux_valid_o(mux_valid_o), .sample_o(sample_o), .conv_start_o(conv_start_o),
  .adc_code_i(adc_code_i));

`default_nettype wire
